//--- verilog/sbc_pkg.sv
// Function
// - Channel disable command 0x04 stops pass-through and event forwarding to the processor.
// - Packets already queued may still drain after a disable, even before its response.
// - Payload bit 0 of disable is the allow-link-down flag; 1 permits dropping link.
// - Link may drop only when flag set and no other function needs it.
// - Disable command is answered with response type 0x84, response and reason codes.
// - Channel reset command 0x05 returns the channel to its initial state.
// - Transmission may continue until reset response 0x85 is sent, then stops.
// - Network transmit enable 0x06, response 0x86, persists until disable or initial state.
// - While enabled, outgoing packets pass only if source MAC matches a configured unicast.
// - Network transmit disable 0x07 blocks network transmission until re-enabled.
// - Network transmit disable is always accepted unless bad checksum or identifier; response 0x87.
// - Event enable command 0x08 individually enables or disables each standard event.
// - Requester tag byte from event enable goes into every later event packet.
// - Event control bits 0..3: link status, config required, driver status, delayed ready.
// - Packets: 16-byte header, payload, 32-bit checksum, then padding.
package sbc_pkg;
  // Command and response type codes
  localparam logic [7:0] CMD_CH_DISABLE  = 8'h04;
  localparam logic [7:0] CMD_CH_RESET    = 8'h05;
  localparam logic [7:0] CMD_NTX_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_NTX_DISABLE = 8'h07;
  localparam logic [7:0] CMD_EVT_ENABLE  = 8'h08;
  localparam logic [7:0] RSP_FLAG        = 8'h80;
  // Packet layout
  localparam int HDR_BYTES   = 16;
  localparam int PAYLOAD_OFS = 16;
  localparam int CKSUM_BYTES = 4;
  // Response codes
  localparam logic [15:0] RSP_OK       = 16'h0000;
  localparam logic [15:0] RSP_FAILED   = 16'h0001;
  localparam logic [15:0] REASON_NONE  = 16'h0000;
  localparam logic [15:0] REASON_UNSUP = 16'h0003;
  // Event control bit positions
  localparam int EVT_LINK   = 0;
  localparam int EVT_CONFIG = 1;
  localparam int EVT_DRIVER = 2;
  localparam int EVT_DELAY  = 3;
  localparam int EVT_NUM    = 4;
  localparam int ALD_BIT    = 0;
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATE   = 8'h04;
  localparam logic [7:0] REG_IRQ_ST  = 8'h08;
  localparam logic [7:0] REG_IRQ_EN  = 8'h0c;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_MAC_LO  = 8'h14;
  localparam logic [7:0] REG_MAC_HI  = 8'h18;
  localparam logic [7:0] REG_LAST    = 8'h1c;
  // Reset values
  localparam logic [47:0] MAC_RST = 48'h0;
  localparam logic [3:0]  IRQ_EN_RST = 4'h0;
  // Interrupt status bit positions
  localparam int IRQ_CMD   = 0;
  localparam int IRQ_RESET = 1;
  localparam int IRQ_DROP  = 2;
  localparam int IRQ_LINK  = 3;
  localparam int IRQ_NUM   = 4;
  // Command decoder states
  typedef enum logic [3:0] {
    SBC_IDLE = 4'b0001,
    SBC_GRAB = 4'b0010,
    SBC_EXEC = 4'b0100,
    SBC_RESP = 4'b1000
  } sbc_state_t;
endpackage : sbc_pkg

//--- verilog/sbc_mac_match.sv
`timescale 1ns/1ps
`default_nettype none
// Compares a source MAC with a set of configured unicast addresses
module sbc_mac_match #(
  parameter int NUM_MAC = 2
) (
  // Address under test
  input  wire logic [47:0]            src_mac,
  // Configured table
  input  wire logic [NUM_MAC*48-1:0]  mac_table,
  input  wire logic [NUM_MAC-1:0]     mac_valid,
  // Result
  output logic                        hit
);
  logic [NUM_MAC-1:0] hits;
  // One comparator per table entry
  genvar i;
  generate
    for (i = 0; i < NUM_MAC; i++) begin : g_cmp
      assign hits[i] = mac_valid[i] && (mac_table[i*48 +: 48] == src_mac);
    end
  endgenerate
  assign hit = |hits;
endmodule : sbc_mac_match
`default_nettype wire

//--- verilog/sbc_channel.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Sideband channel control command interpreter
module sbc_channel (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Command input, both payload words presented with the header in one cycle
  input  wire logic                  cmd_valid,
  input  wire logic [7:0]            cmd_type,
  input  wire logic                  cmd_ok,
  input  wire logic [31:0]           cmd_word0,
  input  wire logic [31:0]           cmd_word1,
  // Response output
  output logic                       rsp_valid,
  output logic [7:0]                 rsp_type,
  output logic [15:0]                rsp_code,
  output logic [15:0]                rsp_reason,
  input  wire logic                  rsp_sent,
  // Queued packets toward the processor
  input  wire logic                  mp_pkt_valid,
  input  wire logic                  mp_pkt_queued,
  output logic                       mp_pkt_pass,
  output logic                       mp_pkt_drop,
  // Pass-through toward the network
  input  wire logic                  net_pkt_valid,
  input  wire logic [47:0]           net_src_mac,
  output logic                       net_pkt_pass,
  output logic                       net_pkt_drop,
  // Standard events
  input  wire logic [3:0]            evt_raise,
  output logic                       async_event_notice,
  output logic [1:0]                 evt_kind,
  output logic [7:0]                 event_requester_tag,
  // Link control
  input  wire logic                  host_needs_link,
  input  wire logic                  wake_on_lan,
  output logic                       link_down_req,
  // Interrupt
  output logic                       irq
);
  import sbc_pkg::*;

  sbc_state_t   state;
  sbc_state_t   next_state;
  logic [7:0]   cur_type;
  logic [31:0]  cur_w0;
  logic [31:0]  cur_w1;
  logic         cur_ok;
  logic         chan_enabled;
  logic         allow_link_down_flag;
  logic         ntx_enabled;
  logic [EVT_NUM-1:0] evt_enable;
  logic         stopped;
  logic [47:0]  mac0;
  logic [47:0]  mac1;
  logic [1:0]   mac_valid;
  logic         mac_hit;
  logic [IRQ_NUM-1:0] irq_status;
  logic [IRQ_NUM-1:0] irq_enable;
  logic [IRQ_NUM-1:0] irq_set;
  logic [IRQ_NUM-1:0] irq_clr;
  logic         apb_wr;
  logic         apb_rd;
  logic         sw_reset;
  logic         do_exec;
  logic         init_state;
  logic [1:0]   evt_sel;
  logic         evt_any;

  assign apb_wr   = psel && penable && pwrite && pready;
  assign apb_rd   = psel && !penable && !pwrite;
  assign do_exec  = (state == SBC_EXEC) && cur_ok;
  // Initial state is entered by bus reset or by a reset command when it executes, in the cycle its answer is raised
  assign init_state = do_exec && (cur_type == CMD_CH_RESET);
  assign sw_reset = apb_wr && (paddr == REG_CTRL) && pwdata[1];

  // Command sequencer
  always_comb begin
    next_state = state;
    case (state)
      SBC_IDLE: if (cmd_valid) next_state = SBC_GRAB;
      SBC_GRAB: next_state = SBC_EXEC;
      SBC_EXEC: next_state = cur_ok ? SBC_RESP : SBC_IDLE;
      SBC_RESP: if (rsp_sent) next_state = SBC_IDLE;
      default:  next_state = SBC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= SBC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture the command words (payload taken with the header) for execution
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cur_type <= 8'h00;
      cur_w0   <= 32'h0;
      cur_w1   <= 32'h0;
      cur_ok   <= 1'b0;
    end else if (state == SBC_IDLE && cmd_valid) begin
      cur_type <= cmd_type;
      cur_w0   <= cmd_word0;
      cur_w1   <= cmd_word1;
      cur_ok   <= cmd_ok;
    end
  end

  // Channel enable and allow-link-down flag
  always_ff @(posedge clk_sys) begin
    if (!nrst || sw_reset) begin
      chan_enabled         <= 1'b0;
      allow_link_down_flag <= 1'b0;
    end else if (do_exec && cur_type == CMD_CH_DISABLE) begin
      chan_enabled         <= 1'b0;
      allow_link_down_flag <= cur_w0[ALD_BIT];
    end else if (do_exec && cur_type == CMD_CH_RESET) begin
      chan_enabled         <= 1'b0;
      allow_link_down_flag <= 1'b0;
    end else if (apb_wr && paddr == REG_CTRL && pwdata[0]) begin
      chan_enabled         <= 1'b1;
    end
  end

  // Network transmit enable
  always_ff @(posedge clk_sys) begin
    if (!nrst || sw_reset) begin
      ntx_enabled <= 1'b0;
    end else if (init_state) begin
      ntx_enabled <= 1'b0;
    end else if (do_exec && cur_type == CMD_NTX_ENABLE) begin
      ntx_enabled <= 1'b1;
    end else if (do_exec && cur_type == CMD_NTX_DISABLE) begin
      ntx_enabled <= 1'b0;
    end
  end

  // Event enables and requester tag
  always_ff @(posedge clk_sys) begin
    if (!nrst || sw_reset) begin
      evt_enable          <= '0;
      event_requester_tag <= 8'h00;
    end else if (init_state) begin
      evt_enable          <= '0;
    end else if (do_exec && cur_type == CMD_EVT_ENABLE) begin
      evt_enable          <= cur_w1[EVT_NUM-1:0];
      event_requester_tag <= cur_w0[7:0];
    end
  end

  // After the reset response leaves, transmission toward the processor stops
  always_ff @(posedge clk_sys) begin
    if (!nrst || sw_reset) begin
      stopped <= 1'b0;
    end else if (state == SBC_RESP && rsp_sent && cur_type == CMD_CH_RESET && cur_ok) begin
      stopped <= 1'b1;
    end else if (apb_wr && paddr == REG_CTRL && pwdata[0]) begin
      stopped <= 1'b0;
    end
  end

  // Response generation
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rsp_valid  <= 1'b0;
      rsp_type   <= 8'h00;
      rsp_code   <= RSP_OK;
      rsp_reason <= REASON_NONE;
    end else if (state == SBC_EXEC && cur_ok) begin
      rsp_valid  <= 1'b1;
      rsp_type   <= cur_type | RSP_FLAG;
      if (cur_type >= CMD_CH_DISABLE && cur_type <= CMD_EVT_ENABLE) begin
        rsp_code   <= RSP_OK;
        rsp_reason <= REASON_NONE;
      end else begin
        rsp_code   <= RSP_FAILED;
        rsp_reason <= REASON_UNSUP;
      end
    end else if (state == SBC_EXEC) begin
      rsp_valid <= 1'b0;
    end else if (rsp_sent) begin
      rsp_valid <= 1'b0;
    end
  end

  // Processor-bound packets: already queued ones may drain after disable
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mp_pkt_pass <= 1'b0;
      mp_pkt_drop <= 1'b0;
    end else begin
      mp_pkt_pass <= mp_pkt_valid && !stopped && (chan_enabled || mp_pkt_queued);
      mp_pkt_drop <= mp_pkt_valid && (stopped || (!chan_enabled && !mp_pkt_queued));
    end
  end

  // Configured unicast addresses
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mac0      <= MAC_RST;
      mac1      <= MAC_RST;
      mac_valid <= 2'b00;
    end else if (apb_wr && paddr == REG_MAC_LO) begin
      mac0      <= {pwdata[15:0], pwdata[31:0]};
      mac_valid[0] <= 1'b1;
    end else if (apb_wr && paddr == REG_MAC_HI) begin
      mac1      <= {pwdata[15:0], pwdata[31:0]};
      mac_valid[1] <= 1'b1;
    end
  end

  sbc_mac_match #(
    .NUM_MAC (2)
  ) u_match (
    .src_mac   (net_src_mac),
    .mac_table ({mac1, mac0}),
    .mac_valid (mac_valid),
    .hit       (mac_hit)
  );

  // Network pass-through filter
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      net_pkt_pass <= 1'b0;
      net_pkt_drop <= 1'b0;
    end else begin
      net_pkt_pass <= net_pkt_valid && ntx_enabled && mac_hit;
      net_pkt_drop <= net_pkt_valid && !(ntx_enabled && mac_hit);
    end
  end

  // Event selection, lowest enabled bit first
  always_comb begin
    evt_sel = 2'd0;
    evt_any = 1'b0;
    for (int k = EVT_NUM - 1; k >= 0; k--) begin
      if (evt_raise[k] && evt_enable[k]) begin
        evt_sel = k[1:0];
        evt_any = 1'b1;
      end
    end
  end

  // Event notice toward the processor, suppressed when disabled
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      async_event_notice <= 1'b0;
      evt_kind           <= 2'd0;
    end else begin
      async_event_notice <= evt_any && chan_enabled && !stopped;
      evt_kind           <= evt_sel;
    end
  end

  // Link may drop only if allowed and nobody else needs it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      link_down_req <= 1'b0;
    end else begin
      link_down_req <= !chan_enabled && allow_link_down_flag
                       && !host_needs_link && !wake_on_lan;
    end
  end

  // Interrupt events
  assign irq_set[IRQ_CMD]   = do_exec;
  assign irq_set[IRQ_RESET] = init_state;
  assign irq_set[IRQ_DROP]  = net_pkt_valid && !(ntx_enabled && mac_hit);
  assign irq_set[IRQ_LINK]  = link_down_req;
  assign irq_clr = (apb_wr && paddr == REG_IRQ_CLR) ? pwdata[IRQ_NUM-1:0] : '0;

  // Sticky status, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_enable <= IRQ_EN_RST;
    end else if (apb_wr && paddr == REG_IRQ_EN) begin
      irq_enable <= pwdata[IRQ_NUM-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
    end
  end

  // APB ready: no wait state, answer in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'b00 || paddr >= REG_LAST);
    end
  end

  // APB read data, captured in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (apb_rd) begin
      if (paddr == REG_CTRL) begin
        prdata <= {31'h0, chan_enabled};
      end else if (paddr == REG_STATE) begin
        prdata <= {16'h0, event_requester_tag, evt_enable, stopped,
                   ntx_enabled, allow_link_down_flag, chan_enabled};
      end else if (paddr == REG_IRQ_ST) begin
        prdata <= {28'h0, irq_status};
      end else if (paddr == REG_IRQ_EN) begin
        prdata <= {28'h0, irq_enable};
      end else if (paddr == REG_MAC_LO) begin
        prdata <= mac0[31:0];
      end else if (paddr == REG_MAC_HI) begin
        prdata <= mac1[31:0];
      end else begin
        prdata <= 32'h0;
      end
    end
  end
endmodule : sbc_channel
`default_nettype wire

//--- verification/sbc_channel_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the channel command interpreter
module sbc_chk import sbc_pkg::*; (
  // Clock, reset, bus handshake
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Commands and responses
  input wire logic        cmd_valid,
  input wire logic        cmd_ok,
  input wire logic [7:0]  cmd_type,
  input wire logic [31:0] cmd_word0,
  input wire logic [31:0] cmd_word1,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_type,
  input wire logic [15:0] rsp_code,
  input wire logic        rsp_sent,
  // Packets, events, link
  input wire logic        mp_pkt_valid,
  input wire logic        mp_pkt_pass,
  input wire logic        mp_pkt_drop,
  input wire logic        net_pkt_valid,
  input wire logic        net_pkt_pass,
  input wire logic        net_pkt_drop,
  input wire logic        async_event_notice,
  input wire logic [1:0]  evt_kind,
  input wire logic [7:0]  event_requester_tag,
  input wire logic        host_needs_link,
  input wire logic        wake_on_lan,
  input wire logic        link_down_req
);
  logic       ntx_q;
  logic [3:0] en_q;
  logic [7:0] tag_q;
  // Settings mirrored when each response appears
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ntx_q <= 1'b0;
      en_q  <= 4'h0;
      tag_q <= 8'h00;
    end else if ($rose(rsp_valid)) begin
      if (rsp_type == 8'h86) ntx_q <= 1'b1;
      if (rsp_type == 8'h87 || rsp_type == 8'h85) ntx_q <= 1'b0;
      if (rsp_type == 8'h85) en_q <= 4'h0;
      if (rsp_type == 8'h88) en_q <= $past(cmd_word1[3:0], 3);
      if (rsp_type == 8'h88) tag_q <= $past(cmd_word0[7:0], 3);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Command taken while idle, and its answer
  sequence s_take;
    cmd_valid && cmd_ok && !rsp_valid;
  endsequence
  sequence s_answer;
    ##3 rsp_valid && rsp_type == ($past(cmd_type, 3) | RSP_FLAG);
  endsequence
  rsp_timing_a: assert property (s_take |-> s_answer)
    else $error("response late or of wrong type");
  bad_silent_a: assert property (cmd_valid && !cmd_ok && !rsp_valid |-> ##3 !rsp_valid)
    else $error("response to a bad command");
  rsp_hold_a: assert property (rsp_valid && !rsp_sent |=> rsp_valid && $stable(rsp_code))
    else $error("response dropped before sent");
  apb_wait_a: assert property (psel && !penable |=> pready)
    else $error("bus answer not in access cycle");
  ntx_gate_a: assert property (net_pkt_pass |-> ntx_q)
    else $error("network pass while transmit off");
  net_answer_a: assert property (net_pkt_valid |=> net_pkt_pass != net_pkt_drop)
    else $error("network packet not judged");
  mp_answer_a: assert property (mp_pkt_valid |=> mp_pkt_pass != mp_pkt_drop)
    else $error("processor packet not judged");
  evt_gate_a: assert property (async_event_notice |-> en_q[evt_kind] && event_requester_tag == tag_q)
    else $error("event disabled or wrong tag");
  link_keep_a: assert property ($rose(link_down_req) |-> !$past(host_needs_link) && !$past(wake_on_lan))
    else $error("link dropped while needed");
endmodule : sbc_chk
bind sbc_channel sbc_chk u_chk (.*);
`default_nettype wire

//--- verification/sbc_mp_model.sv
`timescale 1ns/1ps
`default_nettype none
// Management processor: sends commands, accepts responses after a stall
module sbc_mp_model (
  // Clock
  input  wire logic        clk_sys,
  // Command side
  output logic             cmd_valid,
  output logic [7:0]       cmd_type,
  output logic             cmd_ok,
  output logic [31:0]      cmd_word0,
  output logic [31:0]      cmd_word1,
  // Response side
  input  wire logic        rsp_valid,
  output logic             rsp_sent,
  input  wire logic [3:0]  stall
);
  int n;
  initial begin
    {cmd_valid, cmd_type, cmd_ok, cmd_word0, cmd_word1, rsp_sent} = '0;
    n = 0;
  end
  // Payload words presented with the header in one cycle; payload lines scramble once released
  task automatic send(input logic [7:0] t, input logic ok, input logic [31:0] w0, w1);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_type  <= t;
    cmd_ok    <= ok;
    cmd_word0 <= w0;
    cmd_word1 <= w1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_word0 <= ~w0;
    cmd_word1 <= ~w1;
  endtask : send
  // Response acknowledged with rsp_sent once it has waited stall cycles
  always @(posedge clk_sys) begin
    if (rsp_valid && !rsp_sent && n >= stall) begin
      rsp_sent <= 1'b1;
      n <= 0;
    end else begin
      rsp_sent <= 1'b0;
      if (rsp_valid && !rsp_sent) n <= n + 1;
    end
  end
endmodule : sbc_mp_model
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench of the channel command interpreter
module tb;
  import sbc_pkg::*;
  logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, irq;
  logic        cmd_valid, cmd_ok, rsp_valid, rsp_sent, mp_pkt_valid, mp_pkt_queued;
  logic        mp_pkt_pass, mp_pkt_drop, net_pkt_valid, net_pkt_pass, net_pkt_drop;
  logic        async_event_notice, host_needs_link, wake_on_lan, link_down_req;
  logic [7:0]  paddr, cmd_type, rsp_type, event_requester_tag;
  logic [31:0] pwdata, prdata, cmd_word0, cmd_word1, rd;
  logic [15:0] rsp_code, rsp_reason;
  logic [47:0] net_src_mac;
  logic [3:0]  evt_raise, stall;
  logic [1:0]  evt_kind;
  int          errors, cmp_count, i;
  localparam logic [47:0] MAC = 48'h1234_1234_1234;

  sbc_channel uut (.*);
  sbc_mp_model mp (.*);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Check after a bounded wait of n edges: counts a mismatch and ends the test if the condition never came
  task automatic tmo(input int n);
    if (i >= n) begin
      errors++;
      end_of_test();
    end
  endtask : tmo

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge clk_sys); i++; end while (pready !== 1'b1 && i < 20);
    tmo(20);
    rd = prdata;
    chk("pslverr", e, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [7:0] t, input logic [31:0] w0, w1, input logic [15:0] c);
    mp.send(t, 1'b1, w0, w1);
    i = 0;
    do begin @(posedge clk_sys); i++; end while (!(rsp_valid && rsp_sent) && i < 40);
    tmo(40);
    chk("rsp_type", t | RSP_FLAG, rsp_type);
    chk("rsp_code", c, rsp_code);
    chk("rsp_reason", c == RSP_OK ? REASON_NONE : REASON_UNSUP, rsp_reason);
  endtask : cmd

  task automatic net(input logic [47:0] m, input logic e);
    @(posedge clk_sys);
    net_pkt_valid <= 1'b1;
    net_src_mac <= m;
    @(posedge clk_sys);
    net_pkt_valid <= 1'b0;
    net_src_mac <= ~m;
    @(posedge clk_sys);
    chk("net_pkt_pass", e, net_pkt_pass);
  endtask : net

  task automatic ev(input int k, input logic e);
    logic s;
    s = 1'b0;
    @(posedge clk_sys);
    evt_raise <= 4'h1 << k;
    @(posedge clk_sys);
    evt_raise <= 4'h0;
    repeat (4) begin
      @(posedge clk_sys);
      if (async_event_notice === 1'b1 && evt_kind === k[1:0]) s = 1'b1;
    end
    chk("async_event_notice", e, s);
  endtask : ev

  // One processor-bound packet, queued before disable or not
  task automatic mpk(input logic q, input logic e);
    @(posedge clk_sys);
    mp_pkt_valid <= 1'b1;
    mp_pkt_queued <= q;
    @(posedge clk_sys);
    mp_pkt_valid <= 1'b0;
    mp_pkt_queued <= 1'b0;
    @(posedge clk_sys);
    chk("mp_pkt_pass", e, mp_pkt_pass);
    chk("mp_pkt_drop", !e, mp_pkt_drop);
  endtask : mpk

  task automatic t_regs;
    apb(1'b0, REG_IRQ_EN, 32'h0, 1'b0);
    chk("irq_en reset", IRQ_EN_RST, rd);
    apb(1'b1, REG_IRQ_EN, 32'h1, 1'b0);
    apb(1'b0, REG_IRQ_EN, 32'h0, 1'b0);
    chk("irq_en", 32'h1, rd);
    apb(1'b1, REG_LAST, 32'hffff_ffff, 1'b1);
    apb(1'b1, REG_CTRL, 32'h1, 1'b0);
    apb(1'b1, REG_MAC_LO, 32'h1234_1234, 1'b0);
    apb(1'b0, REG_MAC_LO, 32'h0, 1'b0);
    chk("mac_lo", 32'h1234_1234, rd);
    apb(1'b1, REG_MAC_HI, 32'h1234_1234, 1'b0);
  endtask : t_regs

  task automatic t_ntx;
    cmd(CMD_NTX_ENABLE, 32'h0, 32'h0, RSP_OK);
    net(MAC, 1'b1);
    net(MAC ^ 48'h1, 1'b0);
    cmd(CMD_NTX_DISABLE, 32'h0, 32'h0, RSP_OK);
    net(MAC, 1'b0);
  endtask : t_ntx

  task automatic t_irq;
    apb(1'b1, REG_IRQ_EN, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("irq masked", 1'b0, irq);
    apb(1'b1, REG_IRQ_EN, 32'h1, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("irq raised", 1'b1, irq);
    apb(1'b1, REG_IRQ_CLR, 32'h1, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", 1'b0, irq);
    apb(1'b0, REG_IRQ_ST, 32'h0, 1'b0);
    chk("irq status", 32'h4, rd);
  endtask : t_irq

  task automatic t_evt;
    stall <= 4'h5;
    cmd(CMD_EVT_ENABLE, 32'h5a, 32'h5, RSP_OK);
    apb(1'b0, REG_STATE, 32'h0, 1'b0);
    chk("state", 32'h5a51, rd);
    for (int k = 0; k < EVT_NUM; k++) ev(k, k == 0 || k == 2);
    chk("event_requester_tag", 8'h5a, event_requester_tag);
    stall <= 4'h0;
  endtask : t_evt

  task automatic t_dis;
    host_needs_link <= 1'b1;
    cmd(CMD_CH_DISABLE, 32'h1, 32'h0, RSP_OK);
    mpk(1'b0, 1'b0);
    mpk(1'b1, 1'b1);
    ev(0, 1'b0);
    host_needs_link <= 1'b0;
    wake_on_lan <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("link_down_req", 1'b0, link_down_req);
    wake_on_lan <= 1'b0;
    i = 0;
    do begin @(posedge clk_sys); i++; end while (link_down_req !== 1'b1 && i < 8);
    chk("link_down_req", 1'b1, link_down_req);
  endtask : t_dis

  task automatic t_rst;
    cmd(CMD_NTX_ENABLE, 32'h0, 32'h0, RSP_OK);
    cmd(CMD_CH_RESET, 32'h0, 32'h0, RSP_OK);
    mpk(1'b1, 1'b0);
    apb(1'b1, REG_CTRL, 32'h1, 1'b0);
    net(MAC, 1'b0);
    ev(0, 1'b0);
    cmd(8'h09, 32'h0, 32'h0, RSP_FAILED);
    mp.send(CMD_NTX_DISABLE, 1'b0, 32'h0, 32'h0);
    repeat (6) @(posedge clk_sys);
    chk("rsp_valid", 1'b0, rsp_valid);
  endtask : t_rst

  initial begin
    {psel, penable, pwrite, paddr, pwdata, stall} = '0;
    {mp_pkt_valid, mp_pkt_queued, net_pkt_valid, net_src_mac, evt_raise} = '0;
    {host_needs_link, wake_on_lan} = '0;
    errors = 0;
    cmp_count = 0;
    nrst = 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_ntx();
    t_irq();
    t_evt();
    t_dis();
    t_rst();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
